// File: rtl/tone_defines.svh
// constants for the buzzer tone generator
`ifndef TONE_DEFINES_SVH
`define TONE_DEFINES_SVH

`define OSC_HZ 32768
`define TICK_HZ 256
`define US_PER_S 64'hf4240
`define PRE_W 12
`define TICK_MASK 12'(`OSC_HZ / `TICK_HZ - 1)
`define STEP_FAST_US 62500
`define STEP_SLOW_US 125000
`define STEP_FAST_MASK 12'(64'h8000 * `STEP_FAST_US / `US_PER_S - 64'h1)
`define STEP_SLOW_MASK 12'(64'h8000 * `STEP_SLOW_US / `US_PER_S - 64'h1)
`define BURST_SHORT_US 31250
`define BURST_LONG_US 125000
`define BURST_W 6
`define BURST_SHORT_TICKS 6'(64'h100 * `BURST_SHORT_US / `US_PER_S)
`define BURST_LONG_TICKS 6'(64'h100 * `BURST_LONG_US / `US_PER_S)
`define BURST_LAST_TICK 6'h01

`define PHASE_W 5
`define PERIOD_BASE 5'h10
`define PERIOD_STEP 5'h04
`define HIGH_BASE_LO 5'h08
`define HIGH_BASE_HI 5'h0c
`define PHASE_ONE 5'h01
`define PHASE_ZERO 5'h00

`define LEVEL_FIRST 3'h0
`define LEVEL_LAST 3'h7
`define LEVEL_ONE 3'h1

`define IDX_CTRL 16'hff44
`define IDX_FREQ 16'hff45
`define BIT_ENABLE 0
`define BIT_DECAY 1
`define BIT_RESTART 2
`define BIT_STEPSEL 3
`define BIT_LENSEL 4
`define BIT_TRIG 5
`define BIT_STOP 6
`define FREQ_LSB 0
`define LVL_LSB 4
`define HTRANS_BUSY_BIT 1
`define HRESP_OKAY 1'b0

`endif

// File: rtl/tone_pkg.sv
// types shared by the buzzer tone generator modules
`include "tone_defines.svh"
package tone_pkg;
  typedef enum logic [1:0] {BURST_IDLE, BURST_WAIT, BURST_RUN} burst_t;
  typedef struct packed {
    logic oscPrev;
    logic [`PRE_W-1:0] pre;
  } div_state_t;
  typedef struct packed {
    logic [`PHASE_W-1:0] phase;
    logic high;
  } wave_state_t;
  typedef struct packed {
    logic toneEnable;
    logic decayEnable;
    logic decayStepSelect;
    logic burstLengthSelect;
    logic [2:0] toneFreqCode;
    logic [2:0] loudnessLevelCode;
    logic [2:0] envLevel;
    burst_t burst;
    logic [`BURST_W-1:0] burstCnt;
    logic wr;
    logic selCtrl;
    logic selFreq;
    logic [31:0] rdata;
    logic out;
  } top_state_t;
endpackage : tone_pkg

// File: rtl/timebase_if.sv
// strobes from the oscillator divider chain
`timescale 1ns/1ps
interface timebase_if;
  logic subFast;
  logic subSlow;
  logic tick;
  logic stepFast;
  logic stepSlow;
  modport src (output subFast, output subSlow, output tick, output stepFast, output stepSlow);
  modport sink (input subFast, input subSlow, input tick, input stepFast, input stepSlow);
endinterface : timebase_if

// File: rtl/osc_divider.sv
// oscillator edge detect and prescaler producing all timing strobes
`timescale 1ns/1ps
`include "tone_defines.svh"
module osc_divider (
  input wire logic clk,
  input wire logic rstn,
  input wire logic osc,
  timebase_if.src tb
);
  tone_pkg::div_state_t state_r;
  tone_pkg::div_state_t state_nxt;
  logic rise;

  // one edge detector feeds tone, tick and envelope so they never drift apart
  always_comb begin
    rise = osc && !state_r.oscPrev;
    tb.subFast = osc ^ state_r.oscPrev;
    tb.subSlow = rise;
    tb.tick = rise && ((state_r.pre & `TICK_MASK) == `TICK_MASK);
    tb.stepFast = rise && ((state_r.pre & `STEP_FAST_MASK) == `STEP_FAST_MASK);
    tb.stepSlow = rise && ((state_r.pre & `STEP_SLOW_MASK) == `STEP_SLOW_MASK);
    state_nxt = state_r;
    state_nxt.oscPrev = osc;
    if (rise) begin
      state_nxt.pre = state_r.pre + `PRE_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end
endmodule : osc_divider

// File: rtl/duty_wave.sv
// tone phase counter and duty comparator
`timescale 1ns/1ps
`include "tone_defines.svh"
module duty_wave (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [2:0] freqCode,
  input wire logic [2:0] level,
  timebase_if.sink tb,
  output logic waveHigh
);
  tone_pkg::wave_state_t state_r;
  tone_pkg::wave_state_t state_nxt;
  logic [`PHASE_W-1:0] period;
  logic [`PHASE_W-1:0] highCnt;
  logic [`PHASE_W-1:0] phaseNext;
  logic strobe;

  always_comb begin
    // upper codes run the same sub-step count at half the sub-step rate
    strobe = freqCode[2] ? tb.subSlow : tb.subFast;
    period = `PHASE_W'(`PERIOD_BASE + {3'h0, freqCode[1:0]} * `PERIOD_STEP);
    highCnt = (freqCode[1] ? `HIGH_BASE_HI : `HIGH_BASE_LO) - {2'h0, level};
    phaseNext = (state_r.phase >= period - `PHASE_ONE) ? `PHASE_ZERO : state_r.phase + `PHASE_ONE;
    state_nxt = state_r;
    if (strobe) begin
      state_nxt.phase = phaseNext;
      state_nxt.high = phaseNext < highCnt;
    end
  end

  assign waveHigh = state_r.high;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end
endmodule : duty_wave

// File: rtl/buzzer_tone_generator.sv
// buzzer tone generator: bus registers, envelope and one-shot control
// Functional notes
// - tone divides oscillator, eight selectable frequencies
// - duty is high time over period
// - level code 0 loudest, 7 quietest
// - period 16/20/24/28, high counts per pair
// - tone out when enabled or burst, else low
// - truncated pulse on switching is allowed
// - envelope overrides level code
// - envelope starts level 1, steps to 8
// - no envelope, fixed level code duty
// - restart returns envelope to level 1
// - level 8 held until off or restart
// - step 125 ms or 62.5 ms
// - burst 125 ms or 31.25 ms
// - burst start and end on 256 Hz tick
// - trigger bit reads busy status
// - force stop ends burst at once
// - trigger clears envelope enable
// - trigger ignored while tone enabled
// - retrigger restarts burst length timer
// - stop wins over simultaneous trigger
// - restart ignored unless active; strobes read 0
// - all control bits reset to zero
//
// Implementation choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "tone_defines.svh"
module buzzer_tone_generator (
  input wire logic clk,
  input wire logic rstn,
  input wire logic lowSpeedOsc,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic toneOut
);
  tone_pkg::top_state_t state_r;
  tone_pkg::top_state_t state_nxt;
  logic waveHigh;
  logic [2:0] activeLevel;
  logic take;
  logic ctrlWr;
  logic freqWr;
  logic trigAccept;
  logic stepStrobe;
  logic toneOn;
  logic [`BURST_W-1:0] burstLenNew;
  logic [31:0] readValue;

  timebase_if tb ();

  // word index sits in haddr[17:2]; upper address bits must be zero
  function automatic logic regHit(input logic [31:0] a, input logic [15:0] idx);
    regHit = (a[31:18] == 14'h0000) && (a[17:2] == idx);
  endfunction : regHit

  osc_divider u_div (
    .clk(clk),
    .rstn(rstn),
    .osc(lowSpeedOsc),
    .tb(tb.src)
  );

  duty_wave u_wave (
    .clk(clk),
    .rstn(rstn),
    .freqCode(state_r.toneFreqCode),
    .level(activeLevel),
    .tb(tb.sink),
    .waveHigh(waveHigh)
  );

  // zero wait state slave, every transfer answers okay
  assign hreadyout = 1'b1;
  assign hresp = `HRESP_OKAY;
  assign hrdata = state_r.rdata;
  assign toneOut = state_r.out;

  assign take = hsel && hready && htrans[`HTRANS_BUSY_BIT];
  assign ctrlWr = state_r.wr && state_r.selCtrl;
  assign freqWr = state_r.wr && state_r.selFreq;
  assign trigAccept = ctrlWr && hwdata[`BIT_TRIG] && !state_r.toneEnable;
  assign activeLevel = state_r.decayEnable ? state_r.envLevel : state_r.loudnessLevelCode;
  assign stepStrobe = state_r.decayStepSelect ? tb.stepSlow : tb.stepFast;
  assign burstLenNew = hwdata[`BIT_LENSEL] ? `BURST_LONG_TICKS : `BURST_SHORT_TICKS;
  assign toneOn = state_r.toneEnable || (state_r.burst == tone_pkg::BURST_RUN);

  always_comb begin
    readValue = '0;
    if (regHit(haddr, `IDX_CTRL)) begin
      readValue[`BIT_ENABLE] = state_r.toneEnable;
      readValue[`BIT_DECAY] = state_r.decayEnable;
      readValue[`BIT_STEPSEL] = state_r.decayStepSelect;
      readValue[`BIT_LENSEL] = state_r.burstLengthSelect;
      readValue[`BIT_TRIG] = state_r.burst != tone_pkg::BURST_IDLE;
    end else if (regHit(haddr, `IDX_FREQ)) begin
      readValue[`FREQ_LSB +: 3] = state_r.toneFreqCode;
      readValue[`LVL_LSB +: 3] = state_r.loudnessLevelCode;
    end
  end

  always_comb begin
    state_nxt = state_r;

    // address phase: remember the target for the data phase
    state_nxt.wr = take && hwrite;
    if (take) begin
      state_nxt.selCtrl = regHit(haddr, `IDX_CTRL);
      state_nxt.selFreq = regHit(haddr, `IDX_FREQ);
      if (!hwrite) begin
        state_nxt.rdata = readValue;
      end
    end

    // envelope stepper, parked at level 1 while the tone is off
    if (!state_r.toneEnable) begin
      state_nxt.envLevel = `LEVEL_FIRST;
    end else if (state_r.decayEnable && stepStrobe && state_r.envLevel != `LEVEL_LAST) begin
      state_nxt.envLevel = state_r.envLevel + `LEVEL_ONE;
    end

    // one-shot sequencer, both edges aligned to the 256 Hz tick
    case (state_r.burst)
      tone_pkg::BURST_WAIT: begin
        if (tb.tick) begin
          state_nxt.burst = tone_pkg::BURST_RUN;
          state_nxt.burstCnt = state_r.burstLengthSelect ? `BURST_LONG_TICKS : `BURST_SHORT_TICKS;
        end
      end
      tone_pkg::BURST_RUN: begin
        if (tb.tick) begin
          if (state_r.burstCnt == `BURST_LAST_TICK) begin
            state_nxt.burst = tone_pkg::BURST_IDLE;
          end else begin
            state_nxt.burstCnt = state_r.burstCnt - `BURST_W'(1);
          end
        end
      end
      default: begin
        state_nxt.burst = tone_pkg::BURST_IDLE;
      end
    endcase

    // data phase writes override the free-running updates above
    if (freqWr) begin
      state_nxt.toneFreqCode = hwdata[`FREQ_LSB +: 3];
      state_nxt.loudnessLevelCode = hwdata[`LVL_LSB +: 3];
    end
    if (ctrlWr) begin
      state_nxt.toneEnable = hwdata[`BIT_ENABLE];
      state_nxt.decayEnable = hwdata[`BIT_DECAY];
      state_nxt.decayStepSelect = hwdata[`BIT_STEPSEL];
      state_nxt.burstLengthSelect = hwdata[`BIT_LENSEL];
      if (hwdata[`BIT_RESTART] && state_r.toneEnable && state_r.decayEnable) begin
        state_nxt.envLevel = `LEVEL_FIRST;
      end
      if (trigAccept) begin
        state_nxt.decayEnable = 1'b0;
      end
      if (hwdata[`BIT_STOP]) begin
        state_nxt.burst = tone_pkg::BURST_IDLE;
      end else if (trigAccept) begin
        if (state_r.burst == tone_pkg::BURST_RUN) begin
          state_nxt.burst = tone_pkg::BURST_RUN;
          state_nxt.burstCnt = burstLenNew;
        end else begin
          state_nxt.burst = tone_pkg::BURST_WAIT;
        end
      end
    end

    // control acts without regard to tone phase, so a cut pulse may appear
    state_nxt.out = toneOn && waveHigh;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  quiet_when_off_a: assert property (
    !toneOn |=> !toneOut
  ) else $error("tone out high while tone off");

  tone_follows_wave_a: assert property (
    toneOn && waveHigh |=> toneOut
  ) else $error("tone out missing while tone on");

  force_stop_a: assert property (
    ctrlWr && hwdata[`BIT_STOP] && !hwdata[`BIT_ENABLE] |=> state_r.burst == tone_pkg::BURST_IDLE ##1 !toneOut
  ) else $error("force stop did not end burst");

  stop_wins_a: assert property (
    ctrlWr && hwdata[`BIT_STOP] && hwdata[`BIT_TRIG] |=> state_r.burst == tone_pkg::BURST_IDLE
  ) else $error("trigger beat force stop");

  trig_ignored_a: assert property (
    ctrlWr && hwdata[`BIT_TRIG] && state_r.toneEnable && state_r.burst == tone_pkg::BURST_IDLE
      |=> state_r.burst == tone_pkg::BURST_IDLE
  ) else $error("trigger taken while tone enabled");

  trig_clears_decay_a: assert property (
    trigAccept |=> !state_r.decayEnable
  ) else $error("trigger left envelope enabled");

  trig_arms_a: assert property (
    trigAccept && !hwdata[`BIT_STOP] && state_r.burst == tone_pkg::BURST_IDLE
      |=> state_r.burst == tone_pkg::BURST_WAIT
  ) else $error("trigger did not arm burst");

  start_on_tick_a: assert property (
    state_r.burst == tone_pkg::BURST_WAIT && !tb.tick && !ctrlWr
      |=> state_r.burst == tone_pkg::BURST_WAIT
  ) else $error("burst started off tick");

  run_on_tick_a: assert property (
    state_r.burst == tone_pkg::BURST_WAIT && tb.tick && !ctrlWr
      |=> state_r.burst == tone_pkg::BURST_RUN
        && state_r.burstCnt == (state_r.burstLengthSelect ? `BURST_LONG_TICKS : `BURST_SHORT_TICKS)
  ) else $error("burst length not loaded on tick");

  retrigger_reload_a: assert property (
    trigAccept && !hwdata[`BIT_STOP] && state_r.burst == tone_pkg::BURST_RUN
      |=> state_r.burstCnt == $past(burstLenNew)
  ) else $error("retrigger did not reload timer");

  env_parked_a: assert property (
    !state_r.toneEnable |=> state_r.envLevel == `LEVEL_FIRST
  ) else $error("envelope not at level one while off");

  env_hold_a: assert property (
    state_r.toneEnable && state_r.envLevel == `LEVEL_LAST && !ctrlWr
      |=> state_r.envLevel == `LEVEL_LAST
  ) else $error("envelope left level eight");

  env_restart_a: assert property (
    ctrlWr && hwdata[`BIT_RESTART] && hwdata[`BIT_ENABLE] && state_r.toneEnable && state_r.decayEnable
      |=> state_r.envLevel == `LEVEL_FIRST
  ) else $error("restart did not reset envelope");

  busy_read_a: assert property (
    take && !hwrite && regHit(haddr, `IDX_CTRL)
      |=> hrdata[`BIT_TRIG] == ($past(state_r.burst) != tone_pkg::BURST_IDLE)
        && !hrdata[`BIT_STOP] && !hrdata[`BIT_RESTART]
  ) else $error("status read mismatch");

  restart_ignored_a: assert property (
    ctrlWr && hwdata[`BIT_RESTART] && state_r.toneEnable && !state_r.decayEnable
      |=> state_r.envLevel == $past(state_r.envLevel)
  ) else $error("restart acted without envelope");

  env_step_a: assert property (
    state_r.toneEnable && state_r.decayEnable && stepStrobe && state_r.envLevel != `LEVEL_LAST && !ctrlWr
      |=> state_r.envLevel == $past(state_r.envLevel) + `LEVEL_ONE
  ) else $error("envelope did not step");

  env_still_a: assert property (
    state_r.toneEnable && !stepStrobe && !ctrlWr |=> state_r.envLevel == $past(state_r.envLevel)
  ) else $error("envelope stepped off strobe");

  env_start_a: assert property (
    !state_r.toneEnable && ctrlWr && hwdata[`BIT_ENABLE] |=> state_r.envLevel == `LEVEL_FIRST
  ) else $error("envelope not at level one on enable");

  level_fixed_a: assert property (
    !state_r.decayEnable |-> activeLevel == state_r.loudnessLevelCode
  ) else $error("level code not used");

  level_env_a: assert property (
    state_r.decayEnable |-> activeLevel == state_r.envLevel
  ) else $error("envelope level not used");

  run_holds_a: assert property (
    state_r.burst == tone_pkg::BURST_RUN && !tb.tick && !ctrlWr |=> state_r.burst == tone_pkg::BURST_RUN
  ) else $error("burst ended off tick");

  burst_count_a: assert property (
    state_r.burst == tone_pkg::BURST_RUN && tb.tick && state_r.burstCnt != `BURST_LAST_TICK && !ctrlWr
      |=> state_r.burstCnt == $past(state_r.burstCnt) - `BURST_W'(1)
  ) else $error("burst timer did not count");

  burst_done_a: assert property (
    state_r.burst == tone_pkg::BURST_RUN && tb.tick && state_r.burstCnt == `BURST_LAST_TICK && !ctrlWr
      |=> state_r.burst == tone_pkg::BURST_IDLE
  ) else $error("burst did not end on tick");

  idle_stays_a: assert property (
    state_r.burst == tone_pkg::BURST_IDLE && !ctrlWr |=> state_r.burst == tone_pkg::BURST_IDLE
  ) else $error("burst started without trigger");

  busy_flag_a: assert property (
    trigAccept && !hwdata[`BIT_STOP] |=> state_r.burst != tone_pkg::BURST_IDLE
  ) else $error("trigger left circuit idle");

  wait_retrig_a: assert property (
    trigAccept && !hwdata[`BIT_STOP] && state_r.burst == tone_pkg::BURST_WAIT
      |=> state_r.burst == tone_pkg::BURST_WAIT
  ) else $error("retrigger left armed state");

  stop_quiet_a: assert property (
    ctrlWr && hwdata[`BIT_STOP] |=> state_r.burst != tone_pkg::BURST_RUN
  ) else $error("burst ran after force stop");

  freq_write_a: assert property (
    freqWr |=> state_r.toneFreqCode == $past(hwdata[`FREQ_LSB +: 3])
  ) else $error("frequency code not written");

  level_write_a: assert property (
    freqWr |=> state_r.loudnessLevelCode == $past(hwdata[`LVL_LSB +: 3])
  ) else $error("level code not written");

  enable_write_a: assert property (
    ctrlWr |=> state_r.toneEnable == $past(hwdata[`BIT_ENABLE])
  ) else $error("tone enable not written");

  decay_write_a: assert property (
    ctrlWr && !trigAccept |=> state_r.decayEnable == $past(hwdata[`BIT_DECAY])
  ) else $error("envelope enable not written");

  select_write_a: assert property (
    ctrlWr |=> state_r.decayStepSelect == $past(hwdata[`BIT_STEPSEL])
      && state_r.burstLengthSelect == $past(hwdata[`BIT_LENSEL])
  ) else $error("time selects not written");

  freq_read_a: assert property (
    take && !hwrite && regHit(haddr, `IDX_FREQ)
      |=> hrdata[`FREQ_LSB +: 3] == $past(state_r.toneFreqCode)
        && hrdata[`LVL_LSB +: 3] == $past(state_r.loudnessLevelCode)
  ) else $error("frequency register read mismatch");

endmodule : buzzer_tone_generator

// File: test/piezo_model.sv
// piezo buzzer model on the shared output pin, measuring tone high time and period
`timescale 1ns/1ps
module piezo_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic toneOut,
  input wire logic tonePinDataBit,
  output int highLen,
  output int periodLen,
  output int pulses
);
  logic pinLevel;
  logic pinPrev;
  int highCnt;
  int perCnt;
  // the pin ors the tone with the port data bit, so a stray 1 there would mask the tone
  assign pinLevel = toneOut | tonePinDataBit;
  // duty is measured as high time over the rise-to-rise period
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pinPrev <= 1'b0;
      highCnt <= 0;
      perCnt <= 0;
      highLen <= 0;
      periodLen <= 0;
      pulses <= 0;
    end else begin
      pinPrev <= pinLevel;
      perCnt <= (pinLevel && !pinPrev) ? 1 : perCnt + 1;
      highCnt <= pinLevel ? (pinPrev ? highCnt + 1 : 1) : 0;
      if (pinLevel && !pinPrev) begin
        periodLen <= perCnt;
        pulses <= pulses + 1;
      end
      if (!pinLevel && pinPrev) begin
        highLen <= highCnt;
      end
    end
  end
endmodule : piezo_model

// File: test/buzzer_tone_generator_bench.sv
// self-checking bench for the buzzer tone generator
`timescale 1ns/1ps
module buzzer_tone_generator_bench;
  localparam logic [31:0] CTRL = 32'h0003fd10;
  localparam logic [31:0] FREQ = 32'h0003fd14;
  localparam int TICK = 256;
  localparam int LIMIT = 90000;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic osc = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic [31:0] hrdata;
  logic hresp;
  logic toneOut;
  logic [31:0] rd;
  logic [15:0] seed = 16'hc6dc;
  int highLen;
  int periodLen;
  int pulses;
  int errTotal = 0;
  int checksDone = 0;
  int cyc = 0;
  int oscRise = 0;
  int t0;
  // expected high counts of the decay envelope, one per step interval
  int envExp[$] = {8, 7, 6, 5, 4, 3, 2, 1, 1};

  always #5 clk = ~clk;
  // the oscillator toggles every clock so the long envelope and burst times stay short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    osc <= ~osc;
    oscRise <= !rstn ? 0 : oscRise + int'(!osc);
    if (cyc == LIMIT) begin
      errTotal++;
      giveVerdict();
    end
  end

  buzzer_tone_generator u_buzzer_tone_generator (.clk(clk), .rstn(rstn), .lowSpeedOsc(osc), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .toneOut(toneOut));
  piezo_model u_piezo_model (.clk(clk), .rstn(rstn), .toneOut(toneOut), .tonePinDataBit(1'b0),
    .highLen(highLen), .periodLen(periodLen), .pulses(pulses));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic int expPer(input logic [2:0] f);
    return (16 + 4 * f[1:0]) * (f[2] ? 2 : 1);
  endfunction : expPer
  function automatic int expHigh(input logic [2:0] f, input int lvl);
    return ((f[1] ? 12 : 8) - lvl) * (f[2] ? 2 : 1);
  endfunction : expHigh

  task automatic giveVerdict();
    $display("errors %0d checks %0d", errTotal, checksDone);
    if (errTotal == 0 && checksDone > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : giveVerdict
  task automatic chkEq(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      errTotal++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chkEq
  task automatic chkIn(input string what, input int lo, input int hi, input int got);
    checksDone++;
    if (got < lo || got > hi) begin
      errTotal++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chkIn
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : xfer
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr
  task automatic rdChk(input string what, input logic [31:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chkEq("response", 32'h0, {31'h0, hresp});
    chkEq(what, exp, rd);
  endtask : rdChk
  // waits three pulses so the measured period is a whole one, not the truncated first
  task automatic tone(input logic [2:0] f, input int lvl);
    int p;
    p = pulses;
    while (pulses < p + 3 && cyc < LIMIT) @(negedge clk);
    chkIn("high time", expHigh(f, lvl), expHigh(f, lvl), highLen);
    chkIn("period", expPer(f), expPer(f), periodLen);
    @(posedge clk);
  endtask : tone
  // keeps envelope samples well clear of the step strobes
  task automatic waitPhase();
    while (oscRise % 2048 == 256) @(posedge clk);
    while (oscRise % 2048 != 256) @(posedge clk);
  endtask : waitPhase
  task automatic burst(input logic [31:0] v, input int lo, input int hi);
    int t;
    t = cyc;
    wr(CTRL, v);
    xfer(CTRL, 1'b0, 32'h0);
    while (rd[5] === 1'b1 && cyc < LIMIT) xfer(CTRL, 1'b0, 32'h0);
    chkIn("burst length", lo, hi, cyc - t);
    chkEq("tone after burst", 32'h0, {31'h0, toneOut});
  endtask : burst

  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chkEq("tone at reset", 32'h0, {31'h0, toneOut});
    rdChk("ctrl reset", CTRL, 32'h0);
    rdChk("freq reset", FREQ, 32'h0);
    wr(FREQ + 32'h8, 32'hff);
    rdChk("unmapped", FREQ + 32'h8, 32'h0);
    wr(FREQ, 32'hffffffff);
    rdChk("freq fields", FREQ, 32'h77);
    wr(CTRL, 32'h1);
    for (int f = 0; f < 8; f++) begin
      seed = lfsr(seed);
      wr(FREQ, {25'h0, seed[2:0], 1'b0, 3'(f)});
      tone(3'(f), int'(seed[2:0]));
    end
    wr(CTRL, 32'h0);
    repeat (3) @(posedge clk);
    t0 = pulses;
    repeat (40) @(posedge clk);
    chkIn("pulses when off", t0, t0, pulses);
    chkEq("tone off", 32'h0, {31'h0, toneOut});
    wr(FREQ, 32'h70);
    waitPhase();
    wr(CTRL, 32'h3);
    foreach (envExp[k]) begin
      if (k > 0) begin
        waitPhase();
      end
      tone(3'h0, 8 - envExp[k]);
    end
    wr(CTRL, 32'h7);
    tone(3'h0, 0);
    rdChk("restart reads 0", CTRL, 32'h3);
    wr(CTRL, 32'hb);
    waitPhase();
    waitPhase();
    tone(3'h0, 1);
    wr(CTRL, 32'h2);
    wr(FREQ, 32'h0);
    t0 = pulses;
    burst(32'h22, 8 * TICK - 16, 9 * TICK + 16);
    chkIn("burst pulses", t0 + 100, t0 + 160, pulses);
    rdChk("decay cleared", CTRL, 32'h0);
    burst(32'h30, 32 * TICK - 16, 33 * TICK + 16);
    wr(CTRL, 32'h20);
    repeat (600) @(posedge clk);
    burst(32'h20, 7 * TICK - 16, 8 * TICK + 16);
    wr(CTRL, 32'h20);
    repeat (600) @(posedge clk);
    wr(CTRL, 32'h40);
    @(posedge clk);
    @(negedge clk);
    chkEq("tone after stop", 32'h0, {31'h0, toneOut});
    @(posedge clk);
    rdChk("busy after stop", CTRL, 32'h0);
    wr(CTRL, 32'h20);
    repeat (600) @(posedge clk);
    wr(CTRL, 32'h60);
    rdChk("trigger with stop", CTRL, 32'h0);
    wr(CTRL, 32'h3);
    wr(CTRL, 32'h23);
    rdChk("trigger while on", CTRL, 32'h3);
    wr(CTRL, 32'h1);
    wr(CTRL, 32'h5);
    rdChk("restart no envelope", CTRL, 32'h1);
    wr(CTRL, 32'h0);
    giveVerdict();
  end
endmodule : buzzer_tone_generator_bench
